// ### fga_gateway.sv
// Top of the gateway actuator command block: configuration sets, scaling, range traffic, commands.
// Assumes a framed HART command arrives as command, byte count and up to two data bytes in one strobe.
//
// How it works
// - Range limits ignored unless variable 0 is primary
// - Remote read-write: write limits after apply
// - Remote read-only: poll limits from holding registers
// - Output variable equals input times scaling factor
// - Restore defaults overwrites config with initial values
// - Save-as-factory copies config into backup set
// - Restore factory copies backup into active config
// - Command 136 echoes index plus type byte
// - Short 136 request answers code 5
// - Command 137 stores type and echoes both bytes
// - Command 137 reports codes 5,6,7,16,32
// - Command 146 returns command byte, position, code 0
`timescale 1ns/1ps
`include "fga_defs.svh"
module fga_gateway (
    // Clock and reset
    input  wire logic                CORE_CLK_I,
    input  wire logic                RST_I,
    // Configuration write port
    input  wire logic                CFG_WR_I,
    input  wire fga_pkg::fga_cfg_t   CFG_DATA_I,
    input  wire logic                CFG_APPLY_I,
    input  wire logic                RESTORE_DEFAULTS_I,
    input  wire logic                SAVE_FACTORY_I,
    input  wire logic                RESTORE_FACTORY_I,
    output fga_pkg::fga_cfg_t        CFG_O,
    // Status inputs from the device
    input  wire logic                WRITE_PROTECT_I,
    input  wire logic                ACCESS_LOCK_I,
    input  wire logic                BUSY_I,
    input  wire logic [7:0]          ACT_COMMAND_I,
    input  wire logic [31:0]         ACT_POSITION_I,
    // Modbus variables and scaled outputs
    input  wire logic [191:0]        MB_VAR_I,
    output logic [191:0]             DEV_VAR_O,
    // Primary variable range
    output logic                     RANGE_VALID_O,
    output logic [31:0]              URV_O,
    output logic [31:0]              LRV_O,
    // Modbus range request
    output logic                     MB_REQ_O,
    output logic [7:0]               MB_FUNC_O,
    output logic [15:0]              MB_ADDR_O,
    output logic [31:0]              MB_WDATA_O,
    output logic [7:0]               MB_DTYPE_O,
    input  wire logic                MB_DONE_I,
    input  wire logic [31:0]         MB_RDATA_I,
    // HART command request
    input  wire logic                CMD_VALID_I,
    input  wire logic [7:0]          CMD_NUM_I,
    input  wire logic [7:0]          CMD_LEN_I,
    input  wire logic [7:0]          CMD_BYTE0_I,
    input  wire logic [7:0]          CMD_BYTE1_I,
    // HART command response
    output logic                     RSP_VALID_O,
    output logic [7:0]               RSP_CODE_O,
    output logic [7:0]               RSP_LEN_O,
    output logic [39:0]              RSP_DATA_O,
    output logic [7:0]               ACT_ROLE_O
);
    // Storage; only registers the reset leaves alone are the nonvolatile set
    fga_pkg::fga_cfg_t cfg_reg;
    fga_pkg::fga_cfg_t backup_reg;
    fga_pkg::fga_cfg_t default_cfg;
    logic [7:0]        role_reg;
    logic              store_init_reg = 1'b0;
    logic [31:0]       poll_cnt_reg;
    logic              poll_tick;
    logic              upper_sel;
    logic              range_en;
    logic [2:0]        var_sel_reg;
    logic [191:0]      dev_var_reg;
    logic [31:0]       scale_sel;
    logic              rsp_valid_reg;
    logic [7:0]        rsp_code_reg;
    logic [7:0]        rsp_len_reg;
    logic [39:0]       rsp_data_reg;
    logic [7:0]        rsp_code_next;
    logic [7:0]        rsp_len_next;
    logic [39:0]       rsp_data_next;
    logic              role_wr;
    logic              is_rd_type;
    logic              is_wr_type;
    logic              is_rd_act;
    logic              role_ok;

    fga_scale_if sif ();

    // System initial values
    assign default_cfg = '{pv_is_dv0: 1'b1, range_remote: 1'b0, range_read_only: 1'b0,
                           data_type: 8'h00, urv: `FGA_URV_INIT, lrv: `FGA_LRV_INIT,
                           urv_addr: `FGA_URV_ADDR_INIT, lrv_addr: `FGA_LRV_ADDR_INIT,
                           scale0: `FGA_SCALE_ONE, scale1: `FGA_SCALE_ONE, scale2: `FGA_SCALE_ONE,
                           scale3: `FGA_SCALE_ONE, scale4: `FGA_SCALE_ONE, scale5: `FGA_SCALE_ONE};

    // Nonvolatile set: first clock after power-up loads defaults, reset never touches it
    always_ff @(posedge CORE_CLK_I) begin
        store_init_reg <= 1'b1;
        if (!store_init_reg || RESTORE_DEFAULTS_I) begin
            cfg_reg <= default_cfg;
        end else if (RESTORE_FACTORY_I) begin
            cfg_reg <= backup_reg;
        end else if (CFG_WR_I) begin
            cfg_reg <= CFG_DATA_I;
        end else if (MB_DONE_I && cfg_reg.range_remote && cfg_reg.range_read_only && range_en) begin
            if (upper_sel) begin
                cfg_reg.urv <= MB_RDATA_I;
            end else begin
                cfg_reg.lrv <= MB_RDATA_I;
            end
        end
        if (!store_init_reg) begin
            backup_reg <= default_cfg;
        end else if (SAVE_FACTORY_I) begin
            backup_reg <= cfg_reg;
        end
        if (!store_init_reg) begin
            role_reg <= `FGA_ROLE_DISABLED;
        end else if (role_wr) begin
            role_reg <= CMD_BYTE1_I;
        end
    end

    // Range limits live only while variable 0 feeds the primary variable
    assign range_en = cfg_reg.pv_is_dv0;

    // Poll divider for remote read-only mode
    assign poll_tick = (poll_cnt_reg == `FGA_POLL_CYC - 1);
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            poll_cnt_reg <= 32'h00000000;
        end else if (poll_tick) begin
            poll_cnt_reg <= 32'h00000000;
        end else begin
            poll_cnt_reg <= poll_cnt_reg + 32'h00000001;
        end
    end

    // Remote range traffic
    fga_range_seq u_seq (
        .clk_i       (CORE_CLK_I),
        .rst_i       (RST_I),
        .enable_i    (range_en && cfg_reg.range_remote),
        .read_only_i (cfg_reg.range_read_only),
        .apply_i     (CFG_APPLY_I),
        .poll_tick_i (poll_tick),
        .mb_req_o    (MB_REQ_O),
        .mb_func_o   (MB_FUNC_O),
        .mb_upper_o  (upper_sel),
        .mb_done_i   (MB_DONE_I)
    );
    // Address and data follow the limit in flight
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            MB_ADDR_O  <= 16'h0000;
            MB_WDATA_O <= 32'h00000000;
            MB_DTYPE_O <= 8'h00;
        end else begin
            MB_ADDR_O  <= upper_sel ? cfg_reg.urv_addr : cfg_reg.lrv_addr;
            MB_WDATA_O <= upper_sel ? cfg_reg.urv : cfg_reg.lrv;
            MB_DTYPE_O <= cfg_reg.data_type;
        end
    end

    // Scaling: one shared multiplier visits the six variables in turn
    assign scale_sel = (var_sel_reg == 3'h0) ? cfg_reg.scale0 :
                       (var_sel_reg == 3'h1) ? cfg_reg.scale1 :
                       (var_sel_reg == 3'h2) ? cfg_reg.scale2 :
                       (var_sel_reg == 3'h3) ? cfg_reg.scale3 :
                       (var_sel_reg == 3'h4) ? cfg_reg.scale4 : cfg_reg.scale5;
    assign sif.operand = MB_VAR_I[var_sel_reg*32 +: 32];
    assign sif.factor  = scale_sel;
    fga_fmul u_mul (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .sif   (sif)
    );
    // Product lands one cycle after its operands, so store under the previous index
    logic [2:0] prev_sel_reg;
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            var_sel_reg  <= 3'h0;
            prev_sel_reg <= 3'h0;
            dev_var_reg  <= 192'h0;
        end else begin
            var_sel_reg  <= (var_sel_reg == 3'h5) ? 3'h0 : var_sel_reg + 3'h1;
            prev_sel_reg <= var_sel_reg;
            dev_var_reg[prev_sel_reg*32 +: 32] <= sif.product;
        end
    end
    assign DEV_VAR_O = dev_var_reg;

    // Range outputs
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RANGE_VALID_O <= 1'b0;
            URV_O         <= 32'h00000000;
            LRV_O         <= 32'h00000000;
            CFG_O         <= '0;
            ACT_ROLE_O    <= 8'h00;
        end else begin
            RANGE_VALID_O <= range_en;
            URV_O         <= range_en ? cfg_reg.urv : 32'h00000000;
            LRV_O         <= range_en ? cfg_reg.lrv : 32'h00000000;
            CFG_O         <= cfg_reg;
            ACT_ROLE_O    <= role_reg;
        end
    end

    // Command decode
    assign is_rd_type = (CMD_NUM_I == `FGA_CMD_RD_TYPE);
    assign is_wr_type = (CMD_NUM_I == `FGA_CMD_WR_TYPE);
    assign is_rd_act  = (CMD_NUM_I == `FGA_CMD_RD_ACT);
    assign role_ok    = (CMD_BYTE1_I <= `FGA_ROLE_TWO_STATE) && (CMD_BYTE0_I == `FGA_TYPE_INDEX);
    assign role_wr    = CMD_VALID_I && is_wr_type && (rsp_code_next == `FGA_RC_OK);

    // Response selection; write errors in priority order
    always_comb begin
        rsp_code_next = `FGA_RC_OK;
        rsp_len_next  = 8'h00;
        rsp_data_next = 40'h0;
        if (is_rd_type) begin
            if (CMD_LEN_I < 8'h01) begin
                rsp_code_next = `FGA_RC_TOO_FEW;
            end else begin
                rsp_len_next  = 8'h02;
                rsp_data_next = {CMD_BYTE0_I, role_reg, 24'h000000};
            end
        end else if (is_wr_type) begin
            if (CMD_LEN_I < 8'h02) begin
                rsp_code_next = `FGA_RC_TOO_FEW;
            end else if (BUSY_I) begin
                rsp_code_next = `FGA_RC_BUSY;
            end else if (ACCESS_LOCK_I) begin
                rsp_code_next = `FGA_RC_RESTRICT;
            end else if (WRITE_PROTECT_I) begin
                rsp_code_next = `FGA_RC_WPROT;
            end else if (!role_ok) begin
                rsp_code_next = `FGA_RC_CMD_ERR;
            end else begin
                rsp_len_next  = 8'h02;
                rsp_data_next = {CMD_BYTE0_I, CMD_BYTE1_I, 24'h000000};
            end
        end else if (is_rd_act) begin
            rsp_len_next  = 8'h05;
            rsp_data_next = {ACT_COMMAND_I, ACT_POSITION_I};
        end
    end

    // Response registers, one-cycle strobe per taken command
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rsp_valid_reg <= 1'b0;
            rsp_code_reg  <= 8'h00;
            rsp_len_reg   <= 8'h00;
            rsp_data_reg  <= 40'h0;
        end else begin
            rsp_valid_reg <= CMD_VALID_I && (is_rd_type || is_wr_type || is_rd_act);
            if (CMD_VALID_I) begin
                rsp_code_reg <= rsp_code_next;
                rsp_len_reg  <= rsp_len_next;
                rsp_data_reg <= rsp_data_next;
            end
        end
    end
    assign RSP_VALID_O = rsp_valid_reg;
    assign RSP_CODE_O  = rsp_code_reg;
    assign RSP_LEN_O   = rsp_len_reg;
    assign RSP_DATA_O  = rsp_data_reg;
endmodule // fga_gateway

// ### fga_defs.svh
// Offsets, codes, power-up values and timing counts for the fieldbus gateway actuator command block.
// Assumes inclusion by bare name from every design file that needs these values.
`ifndef FGA_DEFS_SVH
`define FGA_DEFS_SVH

// Command numbers
`define FGA_CMD_RD_TYPE      8'h88
`define FGA_CMD_WR_TYPE      8'h89
`define FGA_CMD_RD_ACT       8'h92
`define FGA_TYPE_INDEX       8'h31

// Response codes
`define FGA_RC_OK            8'h00
`define FGA_RC_TOO_FEW       8'h05
`define FGA_RC_CMD_ERR       8'h06
`define FGA_RC_WPROT         8'h07
`define FGA_RC_RESTRICT      8'h10
`define FGA_RC_BUSY          8'h20

// Actuator role codes
`define FGA_ROLE_DISABLED    8'h00
`define FGA_ROLE_POSITIONING 8'h01
`define FGA_ROLE_TWO_STATE   8'h02

// Modbus function codes
`define FGA_MB_READ_HOLD     8'h03
`define FGA_MB_WRITE_MULTI   8'h10

// Power-up values: scaling factor 1.0 as IEEE single
`define FGA_SCALE_ONE        32'h3f800000
`define FGA_URV_INIT         32'h43480000
`define FGA_LRV_INIT         32'h00000000
`define FGA_URV_ADDR_INIT    16'h9c40
`define FGA_LRV_ADDR_INIT    16'hc350

// Remote range poll period, 0.2 s update time at 125 MHz
`define FGA_POLL_MS          200
`define FGA_CLK_KHZ          125000
`define FGA_POLL_CYC         (`FGA_POLL_MS * `FGA_CLK_KHZ)

`endif

// ### fga_pkg.sv
// Types shared by the fieldbus gateway actuator command block.
// Assumes fga_defs.svh supplies the numeric values.
package fga_pkg;
    typedef struct packed {
        logic        pv_is_dv0;
        logic        range_remote;
        logic        range_read_only;
        logic [7:0]  data_type;
        logic [31:0] urv;
        logic [31:0] lrv;
        logic [15:0] urv_addr;
        logic [15:0] lrv_addr;
        logic [31:0] scale0;
        logic [31:0] scale1;
        logic [31:0] scale2;
        logic [31:0] scale3;
        logic [31:0] scale4;
        logic [31:0] scale5;
    } fga_cfg_t;
endpackage

// ### fga_scale_if.sv
// Interface carrying one scaling request and its product between modules.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/1ps
interface fga_scale_if;
    logic [31:0] operand;
    logic [31:0] factor;
    logic [31:0] product;
    modport requester (output operand, output factor, input product);
    modport scaler    (input operand, input factor, output product);
endinterface

// ### fga_fmul.sv
// Single-precision multiplier, truncating, flushing denormals to zero.
// Assumes operands are normal IEEE single values or zero; no NaN handling.
`timescale 1ns/1ps
module fga_fmul (
    // Clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    // Operands and product
    fga_scale_if.scaler sif
);
    logic        sgn;
    logic [9:0]  exp_sum;
    logic [47:0] mant;
    logic        zero_in;
    logic [9:0]  exp_adj;
    logic [22:0] frac;
    logic [31:0] product_reg;

    // Combinational product terms
    assign sgn     = sif.operand[31] ^ sif.factor[31];
    assign zero_in = (sif.operand[30:23] == 8'h00) || (sif.factor[30:23] == 8'h00);
    assign mant    = {1'b1, sif.operand[22:0]} * {1'b1, sif.factor[22:0]};
    assign exp_sum = {2'b00, sif.operand[30:23]} + {2'b00, sif.factor[30:23]} - 10'h07f;
    assign exp_adj = mant[47] ? exp_sum + 10'h001 : exp_sum;
    assign frac    = mant[47] ? mant[46:24] : mant[45:23];

    // Register the product; underflow flushes, overflow saturates
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            product_reg <= 32'h00000000;
        end else if (zero_in || exp_adj[9] || exp_adj == 10'h000) begin
            product_reg <= {sgn, 31'h00000000};
        end else if (exp_adj[8] || exp_adj[7:0] == 8'hff) begin
            product_reg <= {sgn, 8'hfe, 23'h7fffff};
        end else begin
            product_reg <= {sgn, exp_adj[7:0], frac};
        end
    end
    assign sif.product = product_reg;
endmodule // fga_fmul

// ### fga_range_seq.sv
// Sequencer for remote range limit traffic toward the Modbus board.
// Assumes the Modbus engine accepts one request on mb_req_o and pulses mb_done_i.
`timescale 1ns/1ps
`include "fga_defs.svh"
module fga_range_seq (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Configuration
    input  wire logic        enable_i,
    input  wire logic        read_only_i,
    input  wire logic        apply_i,
    input  wire logic        poll_tick_i,
    // Modbus request side
    output logic             mb_req_o,
    output logic [7:0]       mb_func_o,
    output logic             mb_upper_o,
    input  wire logic        mb_done_i
);
    typedef enum logic [1:0] {FGA_SEQ_IDLE, FGA_SEQ_UPPER, FGA_SEQ_LOWER} fga_seq_t;
    fga_seq_t   state_reg;
    fga_seq_t   state_next;
    logic       req_reg;
    logic [7:0] func_reg;
    logic       start;

    // Writes follow an apply, reads follow the poll tick
    assign start = enable_i && (read_only_i ? poll_tick_i : apply_i);

    // Walk upper then lower limit, one request each
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            FGA_SEQ_IDLE:  if (start) state_next = FGA_SEQ_UPPER;
            FGA_SEQ_UPPER: if (mb_done_i) state_next = FGA_SEQ_LOWER;
            FGA_SEQ_LOWER: if (mb_done_i) state_next = FGA_SEQ_IDLE;
        endcase
    end

    // Hold the request and its function code
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= FGA_SEQ_IDLE;
            req_reg   <= 1'b0;
            func_reg  <= 8'h00;
        end else begin
            state_reg <= state_next;
            req_reg   <= (state_next != FGA_SEQ_IDLE);
            if (start && state_reg == FGA_SEQ_IDLE) begin
                func_reg <= read_only_i ? `FGA_MB_READ_HOLD : `FGA_MB_WRITE_MULTI;
            end
        end
    end
    assign mb_req_o   = req_reg;
    assign mb_func_o  = func_reg;
    assign mb_upper_o = (state_reg == FGA_SEQ_UPPER);
endmodule // fga_range_seq

// ### fga_gateway_asserts.sv
// Concurrent checks on the gateway's command answers and range request traffic.
// Assumes it is bound onto fga_gateway and sees only that module's ports.
`timescale 1ns/1ps
module fga_gateway_asserts (
    // Clock, reset and status levels
    input wire logic              CORE_CLK_I, RST_I, CFG_APPLY_I, BUSY_I, ACCESS_LOCK_I, WRITE_PROTECT_I,
    input wire fga_pkg::fga_cfg_t CFG_O,
    // Range and actuator data
    input wire logic              RANGE_VALID_O, MB_REQ_O,
    input wire logic [31:0]       URV_O, LRV_O, ACT_POSITION_I,
    input wire logic [7:0]        MB_FUNC_O, MB_DTYPE_O, ACT_COMMAND_I, ACT_ROLE_O,
    // Command request and response
    input wire logic              CMD_VALID_I, RSP_VALID_O,
    input wire logic [7:0]        CMD_NUM_I, CMD_LEN_I, CMD_BYTE0_I, CMD_BYTE1_I, RSP_CODE_O, RSP_LEN_O,
    input wire logic [39:0]       RSP_DATA_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // Command decode shared by the properties
    wire is_rd = CMD_VALID_I && CMD_NUM_I == 8'h88;
    wire is_wr = CMD_VALID_I && CMD_NUM_I == 8'h89 && CMD_LEN_I >= 8'h02;
    wire is_act = CMD_VALID_I && CMD_NUM_I == 8'h92;
    wire wr_clean = !BUSY_I && !ACCESS_LOCK_I && !WRITE_PROTECT_I;
    // Accepted type write: clean request, echo answer, then stored role
    sequence s_wr_ok;
        is_wr && wr_clean && CMD_BYTE0_I == 8'h31 && CMD_BYTE1_I <= 8'h02;
    endsequence
    sequence s_wr_echo;
        RSP_CODE_O == 8'h00 && RSP_LEN_O == 8'h02 && RSP_DATA_O[39:24] == {8'h31, $past(CMD_BYTE1_I)};
    endsequence
    a_wr_store: assert property (s_wr_ok |=> s_wr_echo ##1 ACT_ROLE_O == $past(CMD_BYTE1_I, 2))
        else $error("accepted type write not echoed or stored");
    a_wr_busy: assert property (is_wr && BUSY_I |=> RSP_CODE_O == 8'h20 ##1 $stable(ACT_ROLE_O))
        else $error("busy type write not refused");
    a_rd_short: assert property (is_rd && CMD_LEN_I == 8'h00 |=> RSP_VALID_O && RSP_CODE_O == 8'h05)
        else $error("short type read not answered with code 5");
    a_rd_echo: assert property (is_rd && CMD_LEN_I != 8'h00 |=> RSP_CODE_O == 8'h00
        && RSP_DATA_O[39:24] == {8'h31, ACT_ROLE_O})
        else $error("type read answer wrong");
    a_act_read: assert property (is_act |=> RSP_VALID_O && RSP_CODE_O == 8'h00 && RSP_LEN_O == 8'h05
        && RSP_DATA_O == {$past(ACT_COMMAND_I), $past(ACT_POSITION_I)})
        else $error("actuator read answer wrong");
    a_rsp_single: assert property (RSP_VALID_O && !CMD_VALID_I |=> !RSP_VALID_O)
        else $error("response valid longer than one cycle");
    a_range_off: assert property (!RANGE_VALID_O |-> URV_O == 32'h0 && LRV_O == 32'h0)
        else $error("range limits shown while invalid");
    a_no_req: assert property (!MB_REQ_O ##1 !CFG_O.pv_is_dv0 |-> !MB_REQ_O)
        else $error("range request while variable 0 not primary");
    a_apply_req: assert property (CFG_APPLY_I && CFG_O.pv_is_dv0 && CFG_O.range_remote && !CFG_O.range_read_only
        && !MB_REQ_O |=> MB_REQ_O ##1 MB_FUNC_O == 8'h10 && MB_DTYPE_O == CFG_O.data_type)
        else $error("apply did not start a range write");
    a_poll_func: assert property (MB_REQ_O && $past(MB_REQ_O) && CFG_O.range_read_only |-> MB_FUNC_O == 8'h03)
        else $error("read-only range traffic not a holding read");
endmodule // fga_gateway_asserts

bind fga_gateway fga_gateway_asserts u_chk (.*);

// ### fga_mb_slave.sv
// Behavioural Modbus slave board answering range limit requests.
// Assumes requests stay up until done and the address settles one cycle after each done.
`timescale 1ns/1ps
module fga_mb_slave (
    // Clock, reset and request
    input  wire logic        clk_i, rst_i, req_i,
    input  wire logic [7:0]  func_i, lat_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [31:0] wdata_i,
    // Answer
    output logic             done_o,
    output logic [31:0]      rdata_o
);
    logic [31:0] mem [logic [15:0]];
    // One request at a time, latency of at least one cycle
    initial begin
        done_o = 1'b0;
        rdata_o = 32'h5a5a_a5a5;
        forever begin
            @(posedge clk_i);
            if (!rst_i && req_i) begin
                repeat (lat_i) @(posedge clk_i);
                #1;
                if (func_i == 8'h10) mem[addr_i] = wdata_i;
                rdata_o = mem.exists(addr_i) ? mem[addr_i] : {addr_i, ~addr_i};
                done_o = 1'b1;
                @(posedge clk_i);
                #1;
                done_o = 1'b0;
                rdata_o = ~rdata_o; // Stale read data must not linger
                @(posedge clk_i);
            end
        end
    end
endmodule // fga_mb_slave

// ### testbench.sv
// Self-checking bench for the gateway: config sets, scaling, range writes, actuator commands.
// Assumes the Modbus board model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "fga_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic CORE_CLK_I = 1'b0, RST_I, WRITE_PROTECT_I, ACCESS_LOCK_I, BUSY_I, CMD_VALID_I;
    logic [4:0] ops;
    logic [7:0] ACT_COMMAND_I, CMD_NUM_I, CMD_LEN_I, CMD_BYTE0_I, CMD_BYTE1_I, lat, role, l8, f8, b0, b1, c8;
    logic [31:0] ACT_POSITION_I;
    logic [191:0] MB_VAR_I;
    fga_pkg::fga_cfg_t CFG_DATA_I, d, a, b;
    int mismatches = 0, comparisons = 0, cycles = 0, i, k;
    logic [39:0] tbl [9] = '{40'h02_00_31_00_00, 40'h01_00_31_01_05, 40'h02_07_31_01_20, 40'h02_03_31_01_10,
        40'h02_01_31_01_07, 40'h02_00_32_01_06, 40'h02_00_31_03_06, 40'h02_00_31_02_00, 40'h02_00_31_01_00};
    logic [7:0] acts [6] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
    fga_gateway uut (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CFG_WR_I(ops[4]), .CFG_DATA_I(CFG_DATA_I),
        .CFG_APPLY_I(ops[0]), .RESTORE_DEFAULTS_I(ops[1]), .SAVE_FACTORY_I(ops[2]), .RESTORE_FACTORY_I(ops[3]),
        .CFG_O(), .WRITE_PROTECT_I(WRITE_PROTECT_I), .ACCESS_LOCK_I(ACCESS_LOCK_I), .BUSY_I(BUSY_I),
        .ACT_COMMAND_I(ACT_COMMAND_I), .ACT_POSITION_I(ACT_POSITION_I), .MB_VAR_I(MB_VAR_I), .DEV_VAR_O(),
        .RANGE_VALID_O(), .URV_O(), .LRV_O(), .MB_REQ_O(), .MB_FUNC_O(), .MB_ADDR_O(), .MB_WDATA_O(),
        .MB_DTYPE_O(), .MB_DONE_I(mb.done_o), .MB_RDATA_I(mb.rdata_o), .CMD_VALID_I(CMD_VALID_I),
        .CMD_NUM_I(CMD_NUM_I), .CMD_LEN_I(CMD_LEN_I), .CMD_BYTE0_I(CMD_BYTE0_I), .CMD_BYTE1_I(CMD_BYTE1_I),
        .RSP_VALID_O(), .RSP_CODE_O(), .RSP_LEN_O(), .RSP_DATA_O(), .ACT_ROLE_O());
    fga_mb_slave mb (.clk_i(CORE_CLK_I), .rst_i(RST_I), .req_i(uut.MB_REQ_O), .func_i(uut.MB_FUNC_O),
        .lat_i(lat), .addr_i(uut.MB_ADDR_O), .wdata_i(uut.MB_WDATA_O), .done_o(), .rdata_o());
    // 125 MHz clock
    initial forever #4 CORE_CLK_I = ~CORE_CLK_I;
    // Hang guard, well above the run's length
    always @(posedge CORE_CLK_I) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    function automatic fga_pkg::fga_cfg_t mk(logic pv, rem, ro, logic [31:0] u, sc);
        return '{pv, rem, ro, 8'h02, u, 32'h3f00_0000, 16'h1111, 16'h2222, sc, sc, sc, sc, sc, sc};
    endfunction
    task automatic wcfg(input fga_pkg::fga_cfg_t c);
        CFG_DATA_I = c;
        op(4);
    endtask
    // Strobe: 0 apply, 1 defaults, 2 save, 3 restore backup, 4 write
    task automatic op(input int n);
        @(negedge CORE_CLK_I);
        ops[n] = 1'b1;
        @(negedge CORE_CLK_I);
        ops[n] = 1'b0;
        @(negedge CORE_CLK_I);
    endtask
    // Answer is checked one negedge after the take edge, while it stands
    task automatic cmd(input logic [7:0] n, l, x0, x1);
        @(negedge CORE_CLK_I);
        {CMD_NUM_I, CMD_LEN_I, CMD_BYTE0_I, CMD_BYTE1_I} = {n, l, x0, x1};
        CMD_VALID_I = 1'b1;
        @(negedge CORE_CLK_I);
        CMD_VALID_I = 1'b0;
    endtask
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        {ops, WRITE_PROTECT_I, ACCESS_LOCK_I, BUSY_I, CMD_VALID_I} = '0;
        {CMD_NUM_I, CMD_LEN_I, CMD_BYTE0_I, CMD_BYTE1_I, ACT_COMMAND_I} = '0;
        CFG_DATA_I = '0;
        ACT_POSITION_I = 32'h42c8_0000;
        MB_VAR_I = {6{32'h3fc0_0000}};
        lat = 8'h01;
        RST_I = 1'b1;
        repeat (5) @(posedge CORE_CLK_I);
        @(negedge CORE_CLK_I) RST_I = 1'b0;
        repeat (10) @(negedge CORE_CLK_I);
        // Power-up values and scaling by 1.0 then 2.0
        d = mk(1'b1, 1'b0, 1'b0, `FGA_URV_INIT, `FGA_SCALE_ONE);
        {d.lrv, d.urv_addr, d.lrv_addr, d.data_type} = {`FGA_LRV_INIT, `FGA_URV_ADDR_INIT, `FGA_LRV_ADDR_INIT, 8'h00};
        `CHK(uut.CFG_O, d)
        for (i = 0; i < 6; i++) `CHK(uut.DEV_VAR_O[i*32+:32], 32'h3fc0_0000)
        a = mk(1'b1, 1'b0, 1'b0, 32'h4120_0000, 32'h4000_0000);
        wcfg(a);
        repeat (10) @(negedge CORE_CLK_I);
        for (i = 0; i < 6; i++) `CHK(uut.DEV_VAR_O[i*32+:32], 32'h4040_0000)
        // Backup set round trip
        op(2);
        b = mk(1'b0, 1'b1, 1'b1, 32'h4220_0000, `FGA_SCALE_ONE);
        wcfg(b);
        `CHK(uut.CFG_O, b)
        op(3);
        `CHK(uut.CFG_O, a)
        op(1);
        `CHK(uut.CFG_O, d)
        op(3);
        `CHK(uut.CFG_O, a)
        // Type write error ladder, each followed by a type read
        for (i = 0; i < 9; i++) begin
            {l8, f8, b0, b1, c8} = tbl[i];
            {BUSY_I, ACCESS_LOCK_I, WRITE_PROTECT_I} = f8[2:0];
            if (c8 == 8'h00) role = b1;
            cmd(8'h89, l8, b0, b1);
            `CHK({uut.RSP_VALID_O, uut.RSP_CODE_O}, {1'b1, c8})
            if (c8 == 8'h00) `CHK(uut.RSP_DATA_O[39:24], {b0, b1})
            {BUSY_I, ACCESS_LOCK_I, WRITE_PROTECT_I} = 3'b000;
            cmd(8'h88, 8'h01, 8'h31, 8'h00);
            `CHK({uut.RSP_CODE_O, uut.RSP_LEN_O, uut.RSP_DATA_O[39:24]}, {8'h00, 8'h02, 8'h31, role})
        end
        cmd(8'h88, 8'h00, 8'h00, 8'h00);
        `CHK({uut.RSP_VALID_O, uut.RSP_CODE_O}, {1'b1, 8'h05})
        for (i = 0; i < 6; i++) begin
            ACT_COMMAND_I = acts[i];
            cmd(8'h92, 8'h00, 8'h00, 8'h00);
            `CHK({uut.RSP_CODE_O, uut.RSP_LEN_O, uut.RSP_DATA_O}, {8'h00, 8'h05, acts[i], 32'h42c8_0000})
        end
        cmd(8'h90, 8'h00, 8'h00, 8'h00);
        `CHK(uut.RSP_VALID_O, 1'b0)
        // Remote range write, prompt then slow board
        for (k = 0; k < 2; k++) begin
            lat = k ? 8'h06 : 8'h01;
            wcfg(mk(1'b1, 1'b1, 1'b0, 32'h4100_0000 + k, `FGA_SCALE_ONE));
            `CHK(uut.URV_O, 32'h4100_0000 + k)
            op(0);
            for (i = 0; i < 200 && uut.MB_REQ_O; i++) @(negedge CORE_CLK_I);
            `CHK({mb.mem[16'h1111], mb.mem[16'h2222]}, {32'h4100_0000 + k, 32'h3f00_0000})
        end
        wcfg(mk(1'b0, 1'b1, 1'b0, 32'h4100_0000, `FGA_SCALE_ONE));
        op(0);
        repeat (20) @(negedge CORE_CLK_I);
        `CHK({uut.RANGE_VALID_O, uut.URV_O, uut.MB_REQ_O}, 34'h0)
        // Config and role survive a reset
        RST_I = 1'b1;
        @(negedge CORE_CLK_I) RST_I = 1'b0;
        repeat (3) @(negedge CORE_CLK_I);
        `CHK({uut.CFG_O.urv, uut.CFG_O.pv_is_dv0, uut.ACT_ROLE_O}, {32'h4100_0000, 1'b0, role})
        conclude();
    end
endmodule // testbench
